// ---- verilog/sdc_pkg.sv ----
// constants, register map and carrier types of the status, power and datapath control bank
package sdc_pkg;
   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0]  IDX_STATUS      = 8'hC2;
   localparam logic [7:0]  IDX_POWER       = 8'hC3;
   localparam logic [7:0]  IDX_DPATH       = 8'hC4;
   localparam int unsigned ADR_LO          = 2;
   localparam int unsigned ADR_HI          = 9;
   // reset values
   localparam logic [7:0]  RST_STATUS      = 8'h00;
   localparam logic [7:0]  RST_POWER       = 8'h00;
   localparam logic [7:0]  RST_DPATH       = 8'h00;
   // status field positions
   localparam int unsigned STS_REG_OK      = 0;
   localparam int unsigned STS_SAT_END     = 1;
   localparam int unsigned STS_SOFT_DOG    = 2;
   localparam int unsigned STS_DRV_A       = 3;
   localparam int unsigned STS_DRV_B       = 4;
   localparam int unsigned STS_OSC_DOG     = 5;
   localparam logic [7:0]  STS_HW_MASK     = 8'h3F;
   // power mode field positions
   localparam int unsigned PWR_ACTIVE      = 0;
   localparam int unsigned PWR_CHARGE      = 1;
   // datapath control field positions
   localparam int unsigned DP_PEAK         = 0;
   localparam int unsigned DP_TX           = 1;
   localparam int unsigned DP_ADC          = 2;
   // regulator window below set point, in millivolts
   localparam logic [16:0] REG_OK_WIN_MV   = 17'h000C8;
   localparam logic [15:0] SETPT_BASE_MV   = 16'h1388;
   localparam logic [15:0] SETPT_STEP_MV   = 16'h03E8;
   // saturation monitor sequence
   typedef enum logic [1:0] {
      SAT_IDLE = 2'b00,
      SAT_WAIT = 2'b01,
      SAT_END  = 2'b10
   } sdc_sat_state_t;
   // classic wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [31:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } sdc_wb_req_t;
endpackage

// ---- verilog/sdc_status_power_datapath_ctrl.sv ----
// status, power mode and datapath control register bank with its hardware behaviour
// Summary of operation
// - regulator ok while output above set point less 200 mV
// - saturation end set once envelope below threshold
// - time from burst to below-threshold is recorded
// - soft watchdog expiry resets core, sets flag
// - oscillator flag follows abnormal oscillator detection
// - driver b fault bit 4, a bit 3
// - active bit enables all support circuitry
// - charge bit turns regulator current source on
// - source bit picks datapath or converter output
// - peak bit bypasses lowpass with peak detector
// - transmit bit drives serial transmit enable
// - fifo fills only after blanking expires
//
// Implementation choice: register access over Wishbone.
module sdc_status_power_datapath_ctrl #(
   parameter int unsigned DATA_W  = 12,
   parameter int unsigned TIME_W  = 16,
   parameter int unsigned VSEL_W  = 3
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire sdc_pkg::sdc_wb_req_t wb_req_i,
   output logic                      wb_ack_o,
   output logic [31:0]               wb_dat_o,
   input  wire logic [15:0]          regulator_output_i,
   input  wire logic [VSEL_W-1:0]    regulator_voltage_select_i,
   input  wire logic                 burst_done_i,
   input  wire logic                 sat_monitor_enable_i,
   input  wire logic [DATA_W-1:0]    limiter_input_i,
   input  wire logic [DATA_W-1:0]    sat_threshold_i,
   input  wire logic                 soft_dog_expire_i,
   input  wire logic                 osc_abnormal_i,
   input  wire logic                 driver_a_overcurrent_i,
   input  wire logic                 driver_b_overcurrent_i,
   input  wire logic                 driver_fault_logic_enable_i,
   input  wire logic                 echo_enable_i,
   input  wire logic                 blanking_expired_i,
   input  wire logic                 sample_valid_i,
   input  wire logic [DATA_W-1:0]    lowpass_data_i,
   input  wire logic [DATA_W-1:0]    peak_data_i,
   input  wire logic [DATA_W-1:0]    adc_data_i,
   output logic                      core_reset_o,
   output logic [TIME_W-1:0]         saturation_duration_reg_o,
   output logic                      eeprom_enable_o,
   output logic                      supply_monitor_enable_o,
   output logic                      low_noise_amp_enable_o,
   output logic                      driver_diag_enable_o,
   output logic                      driver_output_a_enable_o,
   output logic                      driver_output_b_enable_o,
   output logic                      adc_enable_o,
   output logic                      regulator_charge_enable_o,
   output logic                      serial_transmit_enable_o,
   output logic                      fifo_write_o,
   output logic [DATA_W-1:0]         fifo_data_o
);

   ////////////////////////////////////////////////////////////////////////////
   // functions
   // set point in millivolts for a voltage select code
   function automatic logic [15:0] setpoint_mv(input logic [VSEL_W-1:0] vsel);
      logic [31:0] prod;
      prod = 32'(vsel) * 32'(sdc_pkg::SETPT_STEP_MV);
      return sdc_pkg::SETPT_BASE_MV + prod[15:0];
   endfunction

   // true for an addressed, strobed request at a given register index
   function automatic logic hit(input sdc_pkg::sdc_wb_req_t rq, input logic [7:0] idx);
      return rq.cyc && rq.stb && (rq.adr[sdc_pkg::ADR_HI:sdc_pkg::ADR_LO] == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic                    ack;
   logic [31:0]             rdata;
   logic [7:0]              status_rsv;
   logic [7:0]              power;
   logic [7:0]              dpath;
   logic                    reg_ok;
   logic                    sat_end;
   logic                    soft_dog;
   logic                    osc_dog;
   logic                    drv_a;
   logic                    drv_b;
   logic                    core_rst;
   sdc_pkg::sdc_sat_state_t sat_state;
   logic [TIME_W-1:0]       sat_count;
   logic [TIME_W-1:0]       saturation_duration_reg;
   logic                    blank_seen;
   logic                    fifo_wr;
   logic [DATA_W-1:0]       fifo_data;
   logic                    next_ack;
   logic [31:0]             next_rdata;
   logic [7:0]              next_status_rsv;
   logic [7:0]              next_power;
   logic [7:0]              next_dpath;
   logic                    next_reg_ok;
   logic                    next_sat_end;
   logic                    next_soft_dog;
   logic                    next_osc_dog;
   logic                    next_drv_a;
   logic                    next_drv_b;
   logic                    next_core_rst;
   sdc_pkg::sdc_sat_state_t next_sat_state;
   logic [TIME_W-1:0]       next_sat_count;
   logic [TIME_W-1:0]       next_saturation_duration_reg;
   logic                    next_blank_seen;
   logic                    next_fifo_wr;
   logic [DATA_W-1:0]       next_fifo_data;
   logic [7:0]              status_byte;
   logic                    wr_en;

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   // status byte: hardware flags in the low six bits, stored reserved bits above
   always_comb begin
      status_byte                        = status_rsv & ~sdc_pkg::STS_HW_MASK;
      status_byte[sdc_pkg::STS_REG_OK]   = reg_ok;
      status_byte[sdc_pkg::STS_SAT_END]  = sat_end;
      status_byte[sdc_pkg::STS_SOFT_DOG] = soft_dog;
      status_byte[sdc_pkg::STS_DRV_A]    = drv_a;
      status_byte[sdc_pkg::STS_DRV_B]    = drv_b;
      status_byte[sdc_pkg::STS_OSC_DOG]  = osc_dog;
   end

   // ack one cycle after the request and drop it the next, so a held request is not acked in two successive cycles
   always_comb begin
      wr_en           = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0] && !ack;
      next_ack        = wb_req_i.cyc && wb_req_i.stb && !ack;
      next_rdata      = rdata;
      next_status_rsv = status_rsv;
      next_power      = power;
      next_dpath      = dpath;
      if (next_ack && !wb_req_i.we) begin
         next_rdata = 32'h0000_0000;  // unmapped reads return zero
         if (hit(wb_req_i, sdc_pkg::IDX_STATUS)) next_rdata[7:0] = status_byte;
         if (hit(wb_req_i, sdc_pkg::IDX_POWER)) next_rdata[7:0] = power;
         if (hit(wb_req_i, sdc_pkg::IDX_DPATH)) next_rdata[7:0] = dpath;
      end
      if (wr_en && hit(wb_req_i, sdc_pkg::IDX_STATUS)) begin
         next_status_rsv = wb_req_i.dat[7:0] & ~sdc_pkg::STS_HW_MASK;
      end
      if (wr_en && hit(wb_req_i, sdc_pkg::IDX_POWER)) next_power = wb_req_i.dat[7:0];
      if (wr_en && hit(wb_req_i, sdc_pkg::IDX_DPATH)) next_dpath = wb_req_i.dat[7:0];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack        <= 1'b0;
         rdata      <= 32'h0000_0000;
         status_rsv <= sdc_pkg::RST_STATUS;
         power      <= sdc_pkg::RST_POWER;
         dpath      <= sdc_pkg::RST_DPATH;
      end else if (ce_i) begin
         ack        <= next_ack;
         rdata      <= next_rdata;
         status_rsv <= next_status_rsv;
         power      <= next_power;
         dpath      <= next_dpath;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hardware status flags
   // flags are computed from hardware inputs only; no bus path reaches them
   always_comb begin
      next_reg_ok   = ({1'b0, regulator_output_i} + sdc_pkg::REG_OK_WIN_MV) >
                      {1'b0, setpoint_mv(regulator_voltage_select_i)};
      next_soft_dog = soft_dog || soft_dog_expire_i;
      next_core_rst = soft_dog_expire_i;
      next_osc_dog  = osc_abnormal_i;
      next_drv_a    = driver_a_overcurrent_i && driver_fault_logic_enable_i;
      next_drv_b    = driver_b_overcurrent_i && driver_fault_logic_enable_i;
   end

   // the timeout flag stays until the bank itself is reset; the core reset alone does not clear it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_ok   <= 1'b0;
         soft_dog <= 1'b0;
         core_rst <= 1'b0;
         osc_dog  <= 1'b0;
         drv_a    <= 1'b0;
         drv_b    <= 1'b0;
      end else if (ce_i) begin
         reg_ok   <= next_reg_ok;
         soft_dog <= next_soft_dog;
         core_rst <= next_core_rst;
         osc_dog  <= next_osc_dog;
         drv_a    <= next_drv_a;
         drv_b    <= next_drv_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // saturation monitor
   // a new burst restarts timing unless one is still being timed; the counter saturates rather than wrapping
   always_comb begin
      next_sat_state = sat_state;
      next_sat_count = sat_count;
      next_saturation_duration_reg  = saturation_duration_reg;
      next_sat_end   = sat_end;
      case (sat_state)
         sdc_pkg::SAT_IDLE, sdc_pkg::SAT_END: begin
            if (burst_done_i && sat_monitor_enable_i) begin
               next_sat_state = sdc_pkg::SAT_WAIT;
               next_sat_count = '0;
               next_sat_end   = 1'b0;
            end
         end
         sdc_pkg::SAT_WAIT: begin
            if (limiter_input_i < sat_threshold_i) begin
               next_sat_state = sdc_pkg::SAT_END;
               next_sat_end   = 1'b1;
               next_saturation_duration_reg  = sat_count;
            end else if (sat_count != {TIME_W{1'b1}}) begin
               next_sat_count = sat_count + 1'b1;
            end
         end
         default: begin
            next_sat_state = sdc_pkg::SAT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sat_state <= sdc_pkg::SAT_IDLE;
         sat_count <= '0;
         saturation_duration_reg  <= '0;
         sat_end   <= 1'b0;
      end else if (ce_i) begin
         sat_state <= next_sat_state;
         sat_count <= next_sat_count;
         saturation_duration_reg  <= next_saturation_duration_reg;
         sat_end   <= next_sat_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fifo write path
   // blanking is remembered per echo window; dropping echo enable rearms it
   always_comb begin
      next_blank_seen = echo_enable_i && (blank_seen || blanking_expired_i);
      next_fifo_wr    = echo_enable_i && blank_seen && sample_valid_i;
      next_fifo_data  = fifo_data;
      if (sample_valid_i) begin
         if (dpath[sdc_pkg::DP_ADC]) begin
            next_fifo_data = adc_data_i;
         end else if (dpath[sdc_pkg::DP_PEAK]) begin
            next_fifo_data = peak_data_i;
         end else begin
            next_fifo_data = lowpass_data_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blank_seen <= 1'b0;
         fifo_wr    <= 1'b0;
         fifo_data  <= '0;
      end else if (ce_i) begin
         blank_seen <= next_blank_seen;
         fifo_wr    <= next_fifo_wr;
         fifo_data  <= next_fifo_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign wb_ack_o                  = ack;
   assign wb_dat_o                  = rdata;
   assign core_reset_o              = core_rst;
   assign saturation_duration_reg_o = saturation_duration_reg;
   // one bit gates every support block, so they power up and down together
   assign eeprom_enable_o           = power[sdc_pkg::PWR_ACTIVE];
   assign supply_monitor_enable_o   = power[sdc_pkg::PWR_ACTIVE];
   assign low_noise_amp_enable_o    = power[sdc_pkg::PWR_ACTIVE];
   assign driver_diag_enable_o      = power[sdc_pkg::PWR_ACTIVE];
   assign driver_output_a_enable_o  = power[sdc_pkg::PWR_ACTIVE];
   assign driver_output_b_enable_o  = power[sdc_pkg::PWR_ACTIVE];
   assign adc_enable_o              = power[sdc_pkg::PWR_ACTIVE];
   assign regulator_charge_enable_o = power[sdc_pkg::PWR_CHARGE];
   assign serial_transmit_enable_o  = dpath[sdc_pkg::DP_TX];
   assign fifo_write_o              = fifo_wr;
   assign fifo_data_o               = fifo_data;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single_pulse: assert property (ack |=> !ack)
      else $error("ack held for more than one cycle");
   a_regok_window: assert property (ce_i |=> (reg_ok == (({1'b0, $past(regulator_output_i)}
      + sdc_pkg::REG_OK_WIN_MV) > {1'b0, setpoint_mv($past(regulator_voltage_select_i))})))
      else $error("regulator ok flag disagrees with window");
   a_sat_held_low: assert property (sat_state == sdc_pkg::SAT_WAIT |-> !sat_end)
      else $error("saturation end set while echo above threshold");
   a_saturation_duration_reg_record: assert property (ce_i && sat_state == sdc_pkg::SAT_WAIT
      && limiter_input_i < sat_threshold_i |=> sat_end && saturation_duration_reg == $past(sat_count))
      else $error("saturation time not recorded");
   a_core_reset_flag: assert property (ce_i && soft_dog_expire_i |=> core_reset_o && soft_dog)
      else $error("watchdog expiry did not reset core and flag");
   a_soft_flag_sticky: assert property (soft_dog |=> soft_dog)
      else $error("soft watchdog flag cleared");
   a_osc_flag_follow: assert property (ce_i |=> osc_dog == $past(osc_abnormal_i))
      else $error("oscillator flag does not follow detection");
   a_fault_bit_pos: assert property (ack && !$past(wb_req_i.we) && $past(hit(wb_req_i, sdc_pkg::IDX_STATUS))
      |-> wb_dat_o[4:3] == $past({drv_b, drv_a}))
      else $error("driver fault flags at wrong positions");
   a_active_enables: assert property (ce_i && wr_en && hit(wb_req_i, sdc_pkg::IDX_POWER) |=> {eeprom_enable_o,
      supply_monitor_enable_o, low_noise_amp_enable_o, driver_diag_enable_o, driver_output_a_enable_o,
      driver_output_b_enable_o, adc_enable_o} == {7{$past(wb_req_i.dat[sdc_pkg::PWR_ACTIVE])}})
      else $error("support enables disagree with active bit");
   a_charge_follow: assert property (ce_i && wr_en && hit(wb_req_i, sdc_pkg::IDX_POWER)
      |=> regulator_charge_enable_o == $past(wb_req_i.dat[sdc_pkg::PWR_CHARGE]))
      else $error("charge source not following its bit");
   a_fifo_source: assert property (ce_i && sample_valid_i |=> fifo_data_o == ($past(dpath[sdc_pkg::DP_ADC])
      ? $past(adc_data_i) : ($past(dpath[sdc_pkg::DP_PEAK]) ? $past(peak_data_i) : $past(lowpass_data_i))))
      else $error("fifo data from wrong source");
   a_tx_follow: assert property (ce_i && wr_en && hit(wb_req_i, sdc_pkg::IDX_DPATH)
      |=> serial_transmit_enable_o == $past(wb_req_i.dat[sdc_pkg::DP_TX]))
      else $error("transmit enable not following its bit");
   a_fifo_blanking: assert property (fifo_write_o |-> $past(blank_seen) && $past(echo_enable_i))
      else $error("fifo written before blanking expired");

endmodule

// ---- tb/sdc_status_power_datapath_ctrl_test.sv ----
// self-checking testbench for the status, power mode and datapath control bank
module sdc_status_power_datapath_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                 clk_i, rst_i, ce_i, burst, sat_en, sdog, osc, drv_a, drv_b, drv_en, echo, blank, sv;
   logic [15:0]          regulator_output_out;
   logic [2:0]           vsel;
   logic [11:0]          limiter_input, thr, lp, pk, adc, fifo_d;
   sdc_pkg::sdc_wb_req_t wb_req;
   logic                 wb_ack_o, core_rst, charge, ser, fifo_w;
   logic [31:0]          wb_dat_o;
   logic [15:0]          dur;
   logic [6:0]           act;
   int                   error_cnt, total_checks;

   ////////////////////////////////////////////////////////////////////////////////
   // clock at 125 MHz
   always #4 clk_i = ~clk_i;

   sdc_status_power_datapath_ctrl DUT (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .regulator_output_i(regulator_output_out), .regulator_voltage_select_i(vsel), .burst_done_i(burst),
      .sat_monitor_enable_i(sat_en), .limiter_input_i(limiter_input), .sat_threshold_i(thr), .soft_dog_expire_i(sdog),
      .osc_abnormal_i(osc), .driver_a_overcurrent_i(drv_a), .driver_b_overcurrent_i(drv_b),
      .driver_fault_logic_enable_i(drv_en), .echo_enable_i(echo), .blanking_expired_i(blank),
      .sample_valid_i(sv), .lowpass_data_i(lp), .peak_data_i(pk), .adc_data_i(adc), .core_reset_o(core_rst),
      .saturation_duration_reg_o(dur), .eeprom_enable_o(act[0]), .supply_monitor_enable_o(act[1]),
      .low_noise_amp_enable_o(act[2]), .driver_diag_enable_o(act[3]), .driver_output_a_enable_o(act[4]),
      .driver_output_b_enable_o(act[5]), .adc_enable_o(act[6]), .regulator_charge_enable_o(charge),
      .serial_transmit_enable_o(ser), .fifo_write_o(fifo_w), .fifo_data_o(fifo_d)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // verdict, comparison and bus helpers
   task automatic give_verdict();
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle; the request is held until ack is seen at a rising edge, then released for a cycle
   task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {22'h000000, idx, 2'h0}, sel: 4'hF, dat: {24'h000000, d}};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         give_verdict();
      end
      q = wb_dat_o;
      wb_req <= '0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb_xfer(1'h1, idx, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      wb_xfer(1'h0, idx, 8'h00, q);
      chk(q, {24'h000000, exp});
   endtask

   // one sample strobe; the write pulse shows right after the edge that takes the strobe
   task automatic smp(input logic expw, input logic [11:0] expd);
      sv <= 1'h1;
      @(posedge clk_i);
      sv <= 1'h0;
      #1;
      chk(fifo_w, expw);
      if (expw) chk(fifo_d, expd);
      @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rd_chk(sdc_pkg::IDX_STATUS, sdc_pkg::RST_STATUS);
      rd_chk(sdc_pkg::IDX_POWER, sdc_pkg::RST_POWER);
      rd_chk(sdc_pkg::IDX_DPATH, sdc_pkg::RST_DPATH);
      rd_chk(8'hC5, 8'h00); // unmapped place reads zero
      chk({core_rst, charge, ser, fifo_w, act}, 32'h0);
   endtask

   task automatic t_status_ro();
      wr(sdc_pkg::IDX_STATUS, 8'h3F);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h00);
      wr(sdc_pkg::IDX_STATUS, 8'hC0);
      rd_chk(sdc_pkg::IDX_STATUS, 8'hC0);
      wr(sdc_pkg::IDX_STATUS, 8'h00);
   endtask

   task automatic t_power_dpath();
      wr(sdc_pkg::IDX_POWER, 8'h01);
      chk({charge, act}, 32'h7F);
      rd_chk(sdc_pkg::IDX_POWER, 8'h01);
      wr(sdc_pkg::IDX_POWER, 8'h02);
      chk({charge, act}, 32'h80);
      wr(sdc_pkg::IDX_POWER, 8'h00);
      chk({charge, act}, 32'h00);
      wr(sdc_pkg::IDX_DPATH, 8'h02);
      chk(ser, 1'h1);
      rd_chk(sdc_pkg::IDX_DPATH, 8'h02);
      wr(sdc_pkg::IDX_DPATH, 8'h00);
      chk(ser, 1'h0);
   endtask

   // code 2 puts the set point at 7000 mV, so 6801 is inside the window and 6800 is not
   task automatic t_reg_ok();
      vsel <= 3'h2;
      regulator_output_out <= 16'h1A91;
      repeat (3) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h01);
      regulator_output_out <= 16'h1A90;
      repeat (3) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h00);
      regulator_output_out <= 16'h0000;
   endtask

   task automatic t_faults();
      drv_a <= 1'h1;
      drv_b <= 1'h1;
      repeat (3) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h00);
      drv_en <= 1'h1;
      drv_b <= 1'h0;
      repeat (3) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h08);
      drv_a <= 1'h0;
      drv_b <= 1'h1;
      repeat (3) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h10);
      drv_b <= 1'h0;
      osc <= 1'h1;
      repeat (3) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h20);
      osc <= 1'h0;
      repeat (3) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h00);
   endtask

   // with the clock enable low an expiry pulse must leave every flop alone
   task automatic t_ce_freeze();
      ce_i <= 1'h0;
      sdog <= 1'h1;
      @(posedge clk_i);
      sdog <= 1'h0;
      repeat (2) @(posedge clk_i);
      ce_i <= 1'h1;
      @(posedge clk_i);
      chk(core_rst, 1'h0);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h00);
   endtask

   // the flag is sticky until reset, so it is checked twice with idle cycles between
   task automatic t_soft_dog();
      int n;
      n = 0;
      sdog <= 1'h1;
      repeat (3) begin
         @(posedge clk_i);
         sdog <= 1'h0;
         #1;
         if (core_rst === 1'h1) n++;
      end
      @(posedge clk_i);
      chk(n, 1);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h04);
      repeat (5) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h04);
   endtask

   // five waiting cycles above threshold give a recorded duration of five
   task automatic t_saturation();
      regulator_output_out <= 16'h1A91;
      repeat (2) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h05);
      sat_en <= 1'h1;
      thr <= 12'h400;
      limiter_input <= 12'h800;
      burst <= 1'h1;
      @(posedge clk_i);
      burst <= 1'h0;
      repeat (5) @(posedge clk_i);
      limiter_input <= 12'h100;
      @(posedge clk_i);
      #1;
      chk(dur, 16'h0005);
      @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h07);
      limiter_input <= 12'h800;
      burst <= 1'h1;
      @(posedge clk_i);
      burst <= 1'h0;
      rd_chk(sdc_pkg::IDX_STATUS, 8'h05);
      limiter_input <= 12'h100;
      repeat (2) @(posedge clk_i);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h07);
      regulator_output_out <= 16'h0000;
   endtask

   // a reset in mid-run clears the sticky flags and the control bytes
   task automatic t_mid_reset();
      wr(sdc_pkg::IDX_POWER, 8'h03);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      chk({charge, act}, 32'h00);
      rd_chk(sdc_pkg::IDX_STATUS, 8'h00);
   endtask

   task automatic t_fifo();
      logic [7:0] cfg [4];
      logic [11:0] e;
      cfg = '{8'h00, 8'h01, 8'h04, 8'h05};
      wr(sdc_pkg::IDX_POWER, 8'h01);
      lp <= 12'h123;
      pk <= 12'h456;
      adc <= 12'h789;
      echo <= 1'h1;
      @(posedge clk_i);
      smp(1'h0, 12'h000);
      blank <= 1'h1;
      repeat (2) @(posedge clk_i);
      foreach (cfg[i]) begin
         wr(sdc_pkg::IDX_DPATH, cfg[i]);
         e = cfg[i][2] ? 12'h789 : (cfg[i][0] ? 12'h456 : 12'h123);
         smp(1'h1, e);
      end
      echo <= 1'h0;
      @(posedge clk_i);
      smp(1'h0, 12'h000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: every input has a value at time zero, reset held for 12 cycles
   initial begin
      clk_i = 1'h0; rst_i = 1'h1; ce_i = 1'h1; burst = 1'h0; sat_en = 1'h0; sdog = 1'h0; osc = 1'h0;
      drv_a = 1'h0; drv_b = 1'h0; drv_en = 1'h0; echo = 1'h0; blank = 1'h0; sv = 1'h0;
      regulator_output_out = 16'h0000; vsel = 3'h0; limiter_input = 12'h000; thr = 12'h000; lp = 12'h000; pk = 12'h000;
      adc = 12'h000; wb_req = '0; error_cnt = 0; total_checks = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      t_reset();
      t_status_ro();
      t_power_dpath();
      t_reg_ok();
      t_faults();
      t_ce_freeze();
      t_soft_dog();
      t_saturation();
      t_mid_reset();
      t_fifo();
      give_verdict();
   end
endmodule
